// [bst_tap.sv]
`timescale 1ns/1ps
// Contract
// - four-pin test port with state machine, instruction register, data registers
// - tms and tdi taken on each rising test-clock edge
// - test port owns shared pins only while test mode is asserted
// - sixteen-bit instruction; all zeros and all ones select bypass
// - sample/preload and extest drive the boundary register normally
// - clamp, idcode and highz decoded with standard behaviour
// - private code selects an internal data register
// - idcode shifts a fixed 32-bit identity out of tdo
// - every digital pin has a boundary cell; analog and crystal pins none
module bst_tap #(
  parameter int          NPIN    = 8,
  parameter logic [31:0] ID_CODE = 32'h1234_5671  // arbitrary value
) (
  input  wire logic            CLK,
  input  wire logic            RSTN,
  input  wire logic            TEST_MODE,
  input  wire logic            TCK,
  input  wire logic            TMS,
  input  wire logic            TDI,
  input  wire logic [NPIN-1:0] CORE_OUT,
  input  wire logic [NPIN-1:0] CORE_OE,
  input  wire logic [NPIN-1:0] PIN_IN,
  output logic                 TDO,
  output logic                 TDO_OE,
  output logic [NPIN-1:0]      PIN_OUT,
  output logic [NPIN-1:0]      PIN_OE,
  output logic [NPIN-1:0]      CORE_IN
);
  logic [2:0] tck_s;
  logic [1:0] tms_s, tdi_s, mode_s;
  logic [NPIN-1:0] pin_s1, pin_s2;
  bst_pkg::bst_state_t state, next_state;
  logic [15:0] ir_sh, ir;
  logic        byp;
  logic [31:0] id_sh, int_sh, int_reg;
  logic [NPIN-1:0] oe_upd;

  bst_cell_if #(.N(2 * NPIN)) cb ();

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      tck_s  <= 3'h0;
      tms_s  <= 2'h3;
      tdi_s  <= 2'h0;
      mode_s <= 2'h0;
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      tck_s  <= {tck_s[1:0], TCK};
      tms_s  <= {tms_s[0], TMS};
      tdi_s  <= {tdi_s[0], TDI};
      mode_s <= {mode_s[0], TEST_MODE};
      pin_s1 <= PIN_IN;
      pin_s2 <= pin_s1;
    end
  end

  wire tck_rise = tck_s[1] & ~tck_s[2];
  wire tck_fall = ~tck_s[1] & tck_s[2];
  wire tms      = tms_s[1];
  wire tdi      = tdi_s[1];
  wire active   = mode_s[1];
  wire step     = active & tck_rise;

  // instruction decode
  wire is_sample = (ir == bst_pkg::OP_SAMPLE);
  wire is_extest = (ir == bst_pkg::OP_EXTEST);
  wire is_clamp  = (ir == bst_pkg::OP_CLAMP);
  wire is_highz  = (ir == bst_pkg::OP_HIGHZ);
  wire is_id     = (ir == bst_pkg::OP_IDCODE);
  wire is_int    = (ir == bst_pkg::OP_INTSEL);
  wire is_bnd    = is_sample | is_extest;
  wire is_byp    = ~(is_bnd | is_id | is_int);
  wire drive_pins = is_extest | is_clamp;

  always_comb begin
    next_state = state;
    unique case (state)
      bst_pkg::BST_TLR:      next_state = tms ? bst_pkg::BST_TLR : bst_pkg::BST_RTI;
      bst_pkg::BST_RTI:      next_state = tms ? bst_pkg::BST_SEL_DR : bst_pkg::BST_RTI;
      bst_pkg::BST_SEL_DR:   next_state = tms ? bst_pkg::BST_SEL_IR : bst_pkg::BST_CAP_DR;
      bst_pkg::BST_CAP_DR:   next_state = tms ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
      bst_pkg::BST_SHIFT_DR: next_state = tms ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
      bst_pkg::BST_EXIT1_DR: next_state = tms ? bst_pkg::BST_UPD_DR : bst_pkg::BST_PAUSE_DR;
      bst_pkg::BST_PAUSE_DR: next_state = tms ? bst_pkg::BST_EXIT2_DR : bst_pkg::BST_PAUSE_DR;
      bst_pkg::BST_EXIT2_DR: next_state = tms ? bst_pkg::BST_UPD_DR : bst_pkg::BST_SHIFT_DR;
      bst_pkg::BST_UPD_DR:   next_state = tms ? bst_pkg::BST_SEL_DR : bst_pkg::BST_RTI;
      bst_pkg::BST_SEL_IR:   next_state = tms ? bst_pkg::BST_TLR : bst_pkg::BST_CAP_IR;
      bst_pkg::BST_CAP_IR:   next_state = tms ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
      bst_pkg::BST_SHIFT_IR: next_state = tms ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
      bst_pkg::BST_EXIT1_IR: next_state = tms ? bst_pkg::BST_UPD_IR : bst_pkg::BST_PAUSE_IR;
      bst_pkg::BST_PAUSE_IR: next_state = tms ? bst_pkg::BST_EXIT2_IR : bst_pkg::BST_PAUSE_IR;
      bst_pkg::BST_EXIT2_IR: next_state = tms ? bst_pkg::BST_UPD_IR : bst_pkg::BST_SHIFT_IR;
      bst_pkg::BST_UPD_IR:   next_state = tms ? bst_pkg::BST_SEL_DR : bst_pkg::BST_RTI;
    endcase
  end

  wire in_cap_dr = (state == bst_pkg::BST_CAP_DR);
  wire in_sh_dr  = (state == bst_pkg::BST_SHIFT_DR);
  wire in_upd_dr = (state == bst_pkg::BST_UPD_DR);
  wire in_sh_ir  = (state == bst_pkg::BST_SHIFT_IR);

  // boundary register: per digital pin one input cell and one output cell
  assign cb.pin_in  = {pin_s2, CORE_OE & CORE_OUT};
  assign cb.capture = step & in_cap_dr & is_bnd;
  assign cb.shift   = step & in_sh_dr & is_bnd;
  assign cb.update  = step & in_upd_dr & is_bnd;
  assign cb.sin     = tdi;

  bst_chain #(.N(2 * NPIN)) u_chain (
    .CLK  (CLK),
    .RSTN (RSTN),
    .bus  (cb)
  );

  wire dr_out = is_bnd ? cb.sout : is_id ? id_sh[0] : is_int ? int_sh[0] : byp;
  wire tdo_src = in_sh_ir ? ir_sh[0] : dr_out;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state <= bst_pkg::BST_TLR;
    end else if (!active) begin
      state <= bst_pkg::BST_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN || state == bst_pkg::BST_TLR) begin
      ir    <= bst_pkg::OP_IDCODE;
      ir_sh <= 16'h0000;
    end else if (step) begin
      unique case (state)
        bst_pkg::BST_CAP_IR:   ir_sh <= bst_pkg::IR_CAPTURE;
        bst_pkg::BST_SHIFT_IR: ir_sh <= {tdi, ir_sh[15:1]};
        bst_pkg::BST_UPD_IR:   ir    <= ir_sh;
        default:               ir_sh <= ir_sh;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      byp     <= 1'b0;
      id_sh   <= 32'h0000_0000;
      int_sh  <= 32'h0000_0000;
      int_reg <= 32'h0000_0000;
    end else if (step) begin
      if (in_cap_dr) begin
        byp    <= 1'b0;
        id_sh  <= ID_CODE;
        int_sh <= int_reg;
      end else if (in_sh_dr) begin
        byp <= tdi;
        if (is_id) id_sh <= {tdi, id_sh[31:1]};
        if (is_int) int_sh <= {tdi, int_sh[31:1]};
      end else if (in_upd_dr && is_int) begin
        int_reg <= int_sh;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      TDO      <= 1'b0;
      TDO_OE   <= 1'b0;
    end else begin
      if (!active) begin
        TDO_OE <= 1'b0;
      end else if (tck_fall) begin
        TDO    <= tdo_src;
        TDO_OE <= (state == bst_pkg::BST_SHIFT_IR) | (state == bst_pkg::BST_SHIFT_DR);
      end
    end
  end

  genvar p;
  generate
    for (p = 0; p < NPIN; p++) begin : g_oe
      assign oe_upd[p] = cb.upd[p];
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      PIN_OUT <= '0;
      PIN_OE  <= '0;
      CORE_IN <= '0;
    end else if (active && is_highz) begin
      PIN_OE  <= '0;
      CORE_IN <= pin_s2;
    end else if (active && drive_pins) begin
      PIN_OUT <= cb.upd[NPIN-1:0];
      PIN_OE  <= oe_upd | cb.upd[NPIN-1:0];
      CORE_IN <= cb.upd[2*NPIN-1:NPIN];
    end else begin
      PIN_OUT <= CORE_OUT;
      PIN_OE  <= CORE_OE;
      CORE_IN <= pin_s2;
    end
  end
endmodule // bst_tap

// [bst_pkg.sv]
package bst_pkg;
  localparam int        IR_W          = 16;
  localparam logic [15:0] OP_BYPASS0  = 16'h0000;
  localparam logic [15:0] OP_BYPASS1  = 16'hFFFF;
  localparam logic [15:0] OP_SAMPLE   = 16'hFFF8;
  localparam logic [15:0] OP_EXTEST   = 16'hFFE8;
  localparam logic [15:0] OP_CLAMP    = 16'hFFEF;
  localparam logic [15:0] OP_IDCODE   = 16'hFFFE;
  localparam logic [15:0] OP_HIGHZ    = 16'hFFCF;
  localparam logic [15:0] OP_INTSEL   = 16'hFFFD;
  localparam logic [15:0] IR_CAPTURE  = 16'h0001;
  localparam int        RESET_TMS_CNT = 5;
  localparam int        INT_DR_W      = 32;

  typedef enum logic [3:0] {
    BST_TLR, BST_RTI, BST_SEL_DR, BST_CAP_DR, BST_SHIFT_DR, BST_EXIT1_DR, BST_PAUSE_DR,
    BST_EXIT2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR, BST_SHIFT_IR, BST_EXIT1_IR,
    BST_PAUSE_IR, BST_EXIT2_IR, BST_UPD_IR
  } bst_state_t;
endpackage

// [bst_cell_if.sv]
`timescale 1ns/1ps
interface bst_cell_if #(parameter int N = 8);
  logic [N-1:0] pin_in;
  logic         capture;
  logic         shift;
  logic         update;
  logic         sin;
  logic         sout;
  logic [N-1:0] upd;
  modport tap (output capture, shift, update, sin, input sout, upd, pin_in);
  modport chain (input capture, shift, update, sin, pin_in, output sout, upd);
endinterface

// [bst_chain.sv]
`timescale 1ns/1ps
module bst_chain #(
  parameter int N = 8
) (
  input wire logic CLK,
  input wire logic RSTN,
  bst_cell_if.chain bus
);
  logic [N-1:0] cap;
  logic [N-1:0] upd;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cell
      logic next_in;
      // the last cell takes tdi; the others take their upstream neighbour
      if (g == N - 1) begin : g_last
        assign next_in = bus.sin;
      end else begin : g_mid
        assign next_in = cap[g + 1];
      end
      always_ff @(posedge CLK) begin
        if (!RSTN) begin
          cap[g] <= 1'b0;
          upd[g] <= 1'b0;
        end else begin
          if (bus.capture) cap[g] <= bus.pin_in[g];
          else if (bus.shift) cap[g] <= next_in;
          if (bus.update) upd[g] <= cap[g];
        end
      end
    end
  endgenerate
  assign bus.sout = cap[0];
  assign bus.upd  = upd;
endmodule // bst_chain

// [bst_tap_chk.sv]
`timescale 1ns/1ps
module bst_tap_chk #(
  parameter int NPIN = 8
) (
  input wire logic            CLK,
  input wire logic            RSTN,
  input wire logic            TEST_MODE,
  input wire logic            TCK,
  input wire logic [NPIN-1:0] CORE_OUT,
  input wire logic [NPIN-1:0] CORE_OE,
  input wire logic [NPIN-1:0] PIN_IN,
  input wire logic            TDO,
  input wire logic            TDO_OE,
  input wire logic [NPIN-1:0] PIN_OUT,
  input wire logic [NPIN-1:0] PIN_OE,
  input wire logic [NPIN-1:0] CORE_IN
);
  logic       tck_q;
  logic [3:0] age;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // cycles since the sampled test clock last fell
  always_ff @(posedge CLK) begin
    tck_q <= TCK;
    if (!RSTN) age <= 4'hF;
    else if (tck_q && !TCK) age <= 4'h0;
    else if (age != 4'hF) age <= age + 4'h1;
  end
  a_oe_mode_off: assert property (!TEST_MODE [*4] |-> !TDO_OE)
    else $error("tdo enable outside test mode");
  a_pin_out_core: assert property (
    (!TEST_MODE && $stable(CORE_OUT)) [*6] |-> PIN_OUT == CORE_OUT)
    else $error("pin value not from core");
  a_pin_oe_core: assert property (
    (!TEST_MODE && $stable(CORE_OE)) [*6] |-> PIN_OE == CORE_OE)
    else $error("pin enable not from core");
  a_core_in_pad: assert property (
    (!TEST_MODE && $stable(PIN_IN)) [*6] |-> CORE_IN == PIN_IN)
    else $error("core input not from pad");
  a_tdo_fall_edge: assert property (
    $changed(TDO) && TEST_MODE && $past(TEST_MODE, 8) |-> age <= 4'h6)
    else $error("tdo moved away from a falling test clock");
  a_tdo_oe_tck: assert property (
    (TEST_MODE && $stable(TCK)) [*8] |-> $stable(TDO_OE))
    else $error("tdo enable moved without test clock");
  a_reset_clear: assert property ($rose(RSTN) |-> !TDO_OE && !TDO && PIN_OE == '0)
    else $error("outputs not cleared by reset");
  a_tdo_idle: assert property (!TEST_MODE [*6] |-> $stable(TDO))
    else $error("tdo moved outside test mode");
endmodule  // bst_tap_chk
bind bst_tap bst_tap_chk #(.NPIN(NPIN)) i_chk (.*);

// [bst_jtag_model.sv]
`timescale 1ns/1ps
module bst_jtag_model (
  output logic     TCK,
  output logic     TMS,
  output logic     TDI,
  input wire logic TDO
);
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end
  // one test-clock period, tdo taken just before the rise, tdi scrambled after hold
  task automatic step(input logic ms, input logic di, output logic q);
    TMS = ms;
    TDI = di;
    #200 q = TDO;
    TCK = 1'b1;
    #150 TDI = ~di;
    #50 TCK = 1'b0;
  endtask
  task automatic idle();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule  // bst_jtag_model

// [bst_tap_tb.sv]
`timescale 1ns/1ps
module bst_tap_tb;
  localparam logic [31:0] ID = 32'h0A5C_3E27;  // arbitrary value
  logic        CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        TEST_MODE = 1'b0;
  logic        TCK, TMS, TDI, TDO, TDO_OE;
  logic [7:0]  CORE_OUT = 8'h00, CORE_OE = 8'h00, PIN_IN = 8'h00;
  logic [7:0]  PIN_OUT, PIN_OE, CORE_IN;
  logic [15:0] ops[3];
  logic [31:0] exp_q[$], got_q[$];
  logic [31:0] x = 32'h0000_0062;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  event        seen;
  always #25 CLK = ~CLK;
  bst_tap #(.NPIN(8), .ID_CODE(ID)) i_dut (.*);
  bst_jtag_model i_jtag (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO));
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  always @(seen) while (got_q.size() > 0) chk(exp_q.pop_front(), got_q.pop_front());
  task automatic scan(input logic ir, input logic [31:0] v, input int n,
                      input logic [31:0] e, input bit c);
    logic [31:0] q;
    logic        d;
    q = 32'h0000_0000;
    if (c) exp_q.push_back(e);
    @(posedge CLK);
    #1 i_jtag.step(1'b1, 1'b0, d);
    if (ir) i_jtag.step(1'b1, 1'b0, d);
    repeat (2) i_jtag.step(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      i_jtag.step(i == n - 1, v[i], d);
      q[i] = d;
    end
    i_jtag.step(1'b1, 1'b0, d);
    i_jtag.step(1'b0, 1'b0, d);
    if (c) got_q.push_back(q);
    ->seen;
  endtask
  task automatic ins(input logic [15:0] op);
    scan(1'b1, {16'h0000, op}, 16, {16'h0000, bst_pkg::IR_CAPTURE}, 1'b1);
  endtask
  task automatic look(input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    repeat (8) @(posedge CLK);
    #1 got_q.push_back({8'h00, PIN_OUT, PIN_OE, CORE_IN} & m);
    ->seen;
  endtask
  task automatic conclude();
    $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge CLK);
    #1 RSTN = 1'b1;
    x = rnd();
    {CORE_OUT, CORE_OE, PIN_IN} = x[23:0];
    look(x & 32'h00FF_FFFF, 32'h00FF_FFFF);
    $display("normal pins done");
    TEST_MODE = 1'b1;
    repeat (4) @(posedge CLK);
    #1 i_jtag.idle();
    scan(1'b0, rnd(), 32, ID, 1'b1);
    ops = '{bst_pkg::OP_BYPASS0, bst_pkg::OP_BYPASS1, {4'h5, x[11:0]}};
    foreach (ops[k]) begin
      ins(ops[k]);
      x = rnd();
      scan(1'b0, x, 8, {24'h00_0000, x[6:0], 1'b0}, 1'b1);
    end
    $display("bypass done");
    ins(bst_pkg::OP_INTSEL);
    x = rnd();
    scan(1'b0, x, 32, 32'h0000_0000, 1'b0);
    scan(1'b0, ~x, 32, x, 1'b1);
    $display("internal done");
    CORE_OUT = 8'h3C;
    CORE_OE = 8'hFF;
    PIN_IN = 8'h81;
    ins(bst_pkg::OP_SAMPLE);
    scan(1'b0, 32'h0000_00A5, 16, 32'h0000_813C, 1'b1);
    ins(bst_pkg::OP_EXTEST);
    look(32'h00A5_A500, 32'h00FF_FF00);
    ins(bst_pkg::OP_CLAMP);
    look(32'h00A5_A500, 32'h00FF_FF00);
    ins(bst_pkg::OP_HIGHZ);
    look(32'h0000_0000, 32'h0000_FF00);
    ins(bst_pkg::OP_IDCODE);
    scan(1'b0, 32'h0000_0000, 32, ID, 1'b1);
    $display("boundary done");
    TEST_MODE = 1'b0;
    look({8'h00, CORE_OUT, CORE_OE, PIN_IN}, 32'h00FF_FFFF);
    #10 conclude();
  end
endmodule  // bst_tap_tb
